//--- ehci_command_status_regs.sv
`timescale 1ns/1ps
`include "ehci_regs_defs.svh"

// Functional notes
// - frame list size 00 gives 1024, 01 gives 512, 10 gives 256; resets 00
// - size field writable only when programmable list capability is set
// - selected size picks which frame index bits form the list index
// - controller reset returns pipelines, timers, counters, state machines to initial
// - controller reset start aborts any transaction in progress at once
// - controller reset never signals a bus reset on downstream ports
// - configuration space untouched; every operational register reinitialised
// - after controller reset all root ports return to companion controllers
// - reset bit self-clears when done; writing 0 cannot shorten it
// - run executes schedule; stop drains pipeline, halts, reports halted
// - status flags clear by writing 1; writing 0 leaves them; here async advance flag 5 is read-only, cleared only by a reset
// - status shows only pending interrupts and controller states
// - status at 24h: state bits 15-12, halted resets 1, flags 5-0
// - halted 0 while run set; 1 once stopped by software or hardware
// - host system error sets its flag and clears run
// - rollover flag set when frame index bit for list size toggles
module ehci_command_status_regs #(
    parameter int UFRAME_CYCLES     = `UFRAME_CYCLES,
    parameter int CTRL_RESET_CYCLES = `CTRL_RESET_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        programmable_list_cap,
    input  wire logic        pipeline_idle,
    input  wire logic        transfer_done_event,
    input  wire logic        transfer_error_event,
    input  wire logic        port_change_event,
    input  wire logic        host_error_event,
    input  wire logic        async_advance_event,
    input  wire logic        async_schedule_state,
    input  wire logic        periodic_sched_state,
    input  wire logic        empty_async_detect,
    output logic             run_stop,
    output logic             halted_flag,
    output logic             schedule_fetch_en,
    output logic             controller_reset_active,
    output logic             transaction_abort,
    output logic             port_owner_revert,
    output logic      [13:0] frame_index,
    output logic      [9:0]  frame_list_index
);

    // ==========================================================
    // declarations
    frame_if fi ();

    ehci_regs_pkg::ctrl_reset_state_t rst_state_reg;
    ehci_regs_pkg::ctrl_reset_state_t rst_state_next;
    ehci_regs_pkg::run_state_t        run_state_reg;
    ehci_regs_pkg::run_state_t        run_state_next;

    logic [15:0] rst_cnt_reg;
    logic        abort_reg;
    logic        revert_reg;
    logic        soft_reset;
    logic        run_stop_reg;
    logic        run_stop_next;
    logic [1:0]  frame_list_size_reg;
    logic [5:0]  flags_reg;
    logic [5:0]  flags_set;
    logic [5:0]  flags_next;
    logic [31:0] rdata_reg;

    wire         sel_cmd;
    wire         sel_sts;
    wire         wr_cmd;
    wire         wr_sts;
    wire         rst_request;
    wire         rst_done;
    wire         fls_write_ok;
    wire  [1:0]  fls_wdata;
    wire  [31:0] cmd_value;
    wire  [31:0] sts_value;
    wire  [31:0] read_value;
    wire         reset_busy;
    wire         run_halted;

    // ==========================================================
    // state decode
    function automatic logic is_reset_busy(input ehci_regs_pkg::ctrl_reset_state_t st);
        is_reset_busy = (st == ehci_regs_pkg::RST_BUSY);
    endfunction

    function automatic logic is_run_halted(input ehci_regs_pkg::run_state_t st);
        is_run_halted = (st == ehci_regs_pkg::RUN_HALTED);
    endfunction

    assign reset_busy = is_reset_busy(rst_state_reg);
    assign run_halted = is_run_halted(run_state_reg);

    // ==========================================================
    // address decode
    assign sel_cmd = (reg_addr == `USB_COMMAND_OFF);
    assign sel_sts = (reg_addr == `USB_STATUS_OFF);
    assign wr_cmd  = reg_write && sel_cmd;
    assign wr_sts  = reg_write && sel_sts;

    // ==========================================================
    // controller reset sequencer
    assign rst_request = wr_cmd && reg_wdata[`CMD_CTRL_RESET_BIT]
                         && (rst_state_reg == ehci_regs_pkg::RST_IDLE);
    assign rst_done    = (rst_cnt_reg == 16'(CTRL_RESET_CYCLES - 1));

    always_comb begin
        rst_state_next = rst_state_reg;
        case (rst_state_reg)
            ehci_regs_pkg::RST_IDLE: begin
                if (rst_request) begin
                    rst_state_next = ehci_regs_pkg::RST_BUSY;
                end
            end
            ehci_regs_pkg::RST_BUSY: begin
                if (rst_done) begin
                    rst_state_next = ehci_regs_pkg::RST_IDLE;
                end
            end
            default: begin
                rst_state_next = ehci_regs_pkg::RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rst_state_reg <= ehci_regs_pkg::RST_IDLE;
        end else begin
            rst_state_reg <= rst_state_next;
        end
    end

    // zero writes ignored while busy; only the count ends the reset
    always_ff @(posedge core_clk) begin
        if (reset || !reset_busy) begin
            rst_cnt_reg <= 16'h0000;
        end else begin
            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
        end
    end

    // abort and ownership pulses; no bus reset output exists
    always_ff @(posedge core_clk) begin
        if (reset) begin
            abort_reg  <= 1'b0;
            revert_reg <= 1'b0;
        end else begin
            abort_reg  <= rst_request;
            revert_reg <= rst_request;
        end
    end

    // operational state reinitialised by either reset
    assign soft_reset = reset || reset_busy;

    // ==========================================================
    // run/stop and halt
    always_comb begin
        run_stop_next = run_stop_reg;
        if (host_error_event) begin
            run_stop_next = 1'b0;
        end else if (wr_cmd && !rst_request) begin
            run_stop_next = reg_wdata[`CMD_RUN_STOP_BIT];
        end
    end

    always_comb begin
        run_state_next = run_state_reg;
        case (run_state_reg)
            ehci_regs_pkg::RUN_ACTIVE: begin
                if (!run_stop_reg) begin
                    run_state_next = ehci_regs_pkg::RUN_DRAIN;
                end
            end
            ehci_regs_pkg::RUN_DRAIN: begin
                if (run_stop_reg) begin
                    run_state_next = ehci_regs_pkg::RUN_ACTIVE;
                end else if (pipeline_idle) begin
                    run_state_next = ehci_regs_pkg::RUN_HALTED;
                end
            end
            ehci_regs_pkg::RUN_HALTED: begin
                if (run_stop_reg) begin
                    run_state_next = ehci_regs_pkg::RUN_ACTIVE;
                end
            end
            default: begin
                run_state_next = ehci_regs_pkg::RUN_HALTED;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            run_stop_reg  <= 1'b0;
            run_state_reg <= ehci_regs_pkg::RUN_HALTED;
        end else begin
            run_stop_reg  <= run_stop_next;
            run_state_reg <= run_state_next;
        end
    end

    // ==========================================================
    // frame list size
    assign fls_wdata    = reg_wdata[`CMD_FLS_HI:`CMD_FLS_LO];
    assign fls_write_ok = wr_cmd && !rst_request && programmable_list_cap
                          && (fls_wdata != `FLS_RESERVED);

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            frame_list_size_reg <= `FLS_RESET;
        end else if (fls_write_ok) begin
            frame_list_size_reg <= fls_wdata;
        end
    end

    // ==========================================================
    // frame index counter
    assign fi.run       = !run_halted;
    assign fi.list_size = frame_list_size_reg;

    frame_index_counter #(
        .UFRAME_CYCLES (UFRAME_CYCLES)
    ) u_frame_index (
        .core_clk (core_clk),
        .reset    (soft_reset),
        .fi       (fi)
    );

    // ==========================================================
    // status flags, set wins over clear
    assign flags_set[`STS_XFER_DONE_BIT] = transfer_done_event;
    assign flags_set[`STS_XFER_ERR_BIT]  = transfer_error_event;
    assign flags_set[`STS_PORT_CHG_BIT]  = port_change_event;
    assign flags_set[`STS_WRAP_BIT]      = fi.wrap;
    assign flags_set[`STS_HOST_ERR_BIT]  = host_error_event;
    assign flags_set[`STS_ASYNC_ADV_BIT] = async_advance_event;

    genvar g;
    generate
        for (g = 0; g < `STS_W1C_FLAGS; g = g + 1) begin : g_w1c
            assign flags_next[g] = flags_set[g]
                                   || (flags_reg[g] && !(wr_sts && reg_wdata[g]));
        end
    endgenerate

    // read-only flag; only a reset clears it
    assign flags_next[`STS_ASYNC_ADV_BIT] = flags_set[`STS_ASYNC_ADV_BIT]
                                            || flags_reg[`STS_ASYNC_ADV_BIT];

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            flags_reg <= `STS_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ==========================================================
    // read data
    assign cmd_value = {28'h0000000, frame_list_size_reg,
                        reset_busy, run_stop_reg};

    // interrupts and controller states only, reserved bits read zero
    assign sts_value = {16'h0000, async_schedule_state, periodic_sched_state,
                        empty_async_detect, halted_flag, 6'h00, flags_reg};

    assign read_value = sel_cmd ? cmd_value :
                        sel_sts ? sts_value : 32'h00000000;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_read) begin
            rdata_reg <= read_value;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata               = rdata_reg;
    assign run_stop                = run_stop_reg;
    assign halted_flag             = run_halted
                                     && !run_stop_reg;
    assign schedule_fetch_en       = run_stop_reg && !soft_reset;
    assign controller_reset_active = reset_busy;
    assign transaction_abort       = abort_reg;
    assign port_owner_revert       = revert_reg;
    assign frame_index             = fi.frame_index;
    assign frame_list_index        = fi.list_index;

endmodule // ehci_command_status_regs

//--- ehci_regs_checker.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module ehci_regs_checker #(
    parameter int CTRL_RESET_CYCLES = 16
) (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_write,
    input wire logic [31:0] reg_wdata,
    input wire logic        pipeline_idle,
    input wire logic        host_error_event,
    input wire logic        run_stop,
    input wire logic        halted_flag,
    input wire logic        schedule_fetch_en,
    input wire logic        controller_reset_active,
    input wire logic        transaction_abort,
    input wire logic        port_owner_revert
);
    logic [7:0] busy_cnt_reg;
    wire        cmd_wr = reg_write && (reg_addr == 8'h20);
    always_ff @(posedge core_clk) begin
        busy_cnt_reg <= controller_reset_active ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_reset_req;
        cmd_wr && reg_wdata[1] && !controller_reset_active;
    endsequence
    sequence s_drained;
        (!run_stop && pipeline_idle)[*3];
    endsequence
    chk_run_halted: assert property (run_stop |-> !halted_flag)
        else $error("halted while running");
    chk_halt_drain: assert property (s_drained |-> halted_flag)
        else $error("no halt after drain");
    chk_stop_drains: assert property ($fell(run_stop) && !$past(reset)
        && !controller_reset_active |-> !halted_flag) else $error("halted before drain");
    chk_host_err_stop: assert property (host_error_event |=> !run_stop)
        else $error("run kept after host error");
    chk_run_write: assert property (cmd_wr && !reg_wdata[1] && !controller_reset_active
        && !host_error_event |=> run_stop == $past(reg_wdata[0])) else $error("run write lost");
    chk_reset_pulses: assert property (s_reset_req |=> controller_reset_active
        && transaction_abort && port_owner_revert) else $error("reset start wrong");
    chk_abort_once: assert property (transaction_abort |=> !transaction_abort
        && controller_reset_active) else $error("abort pulse wrong");
    chk_reset_stops: assert property (controller_reset_active
        |-> !schedule_fetch_en && (!$past(controller_reset_active) || halted_flag && !run_stop))
        else $error("fetching during reset");
    chk_reset_bound: assert property (controller_reset_active
        |-> busy_cnt_reg <= CTRL_RESET_CYCLES) else $error("reset never ends");
    chk_reset_full: assert property ($fell(controller_reset_active) && !$past(reset)
        |-> $past(busy_cnt_reg) >= CTRL_RESET_CYCLES - 1) else $error("reset cut short");
    chk_hw_reset_vals: assert property ($fell(reset) |-> halted_flag && !run_stop)
        else $error("reset values wrong");
endmodule // ehci_regs_checker

bind ehci_command_status_regs ehci_regs_checker #(.CTRL_RESET_CYCLES(CTRL_RESET_CYCLES)) chk_i (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .pipeline_idle(pipeline_idle), .host_error_event(host_error_event),
    .run_stop(run_stop), .halted_flag(halted_flag), .schedule_fetch_en(schedule_fetch_en),
    .controller_reset_active(controller_reset_active), .transaction_abort(transaction_abort),
    .port_owner_revert(port_owner_revert)
);

//--- ehci_regs_defs.svh
`ifndef EHCI_REGS_DEFS_SVH
`define EHCI_REGS_DEFS_SVH

// ==========================================================
// register offsets
`define USB_COMMAND_OFF     8'h20
`define USB_STATUS_OFF      8'h24

// ==========================================================
// command register fields
`define CMD_RUN_STOP_BIT    0
`define CMD_CTRL_RESET_BIT  1
`define CMD_FLS_LO          2
`define CMD_FLS_HI          3

// ==========================================================
// frame list size codes
`define FLS_1024            2'h0
`define FLS_512             2'h1
`define FLS_256             2'h2
`define FLS_RESERVED        2'h3
`define FLS_RESET           2'h0

// ==========================================================
// status register fields
`define STS_XFER_DONE_BIT   0
`define STS_XFER_ERR_BIT    1
`define STS_PORT_CHG_BIT    2
`define STS_WRAP_BIT        3
`define STS_HOST_ERR_BIT    4
`define STS_ASYNC_ADV_BIT   5
`define STS_HALTED_BIT      12
`define STS_EMPTY_ASYNC_BIT 13
`define STS_PERIODIC_BIT    14
`define STS_ASYNC_BIT       15
`define STS_W1C_FLAGS       5
`define STS_FLAGS_RESET     6'h00
`define STS_HALTED_RESET    1'h1

// ==========================================================
// frame index wrap bits
`define WRAP_BIT_1024       13
`define WRAP_BIT_512        12
`define WRAP_BIT_256        11

// ==========================================================
// timing
`define CLK_PERIOD_NS       10
`define UFRAME_NS           125000
`define UFRAME_CYCLES       (`UFRAME_NS / `CLK_PERIOD_NS)
`define CTRL_RESET_CYCLES   16

`endif

//--- ehci_regs_pkg.sv
// ==========================================================
// shared types
package ehci_regs_pkg;

    typedef enum logic [1:0] {
        RUN_ACTIVE,
        RUN_DRAIN,
        RUN_HALTED
    } run_state_t;

    typedef enum logic {
        RST_IDLE,
        RST_BUSY
    } ctrl_reset_state_t;

endpackage

//--- frame_if.sv
`timescale 1ns/1ps

// ==========================================================
// frame index carrier
interface frame_if;
    logic        run;
    logic [1:0]  list_size;
    logic [13:0] frame_index;
    logic [9:0]  list_index;
    logic        wrap;

    modport counter (
        input  run,
        input  list_size,
        output frame_index,
        output list_index,
        output wrap
    );

    modport ctrl (
        output run,
        output list_size,
        input  frame_index,
        input  list_index,
        input  wrap
    );
endinterface // frame_if

//--- frame_index_counter.sv
`timescale 1ns/1ps
`include "ehci_regs_defs.svh"

module frame_index_counter #(
    parameter int UFRAME_CYCLES = `UFRAME_CYCLES
) (
    input  wire logic   core_clk,
    input  wire logic   reset,
    frame_if.counter    fi
);

    // ==========================================================
    // microframe divider
    logic [31:0] div_reg;
    logic        tick;
    logic [13:0] index_reg;
    logic [13:0] index_next;
    logic        wrap_reg;
    logic [9:0]  list_index_reg;
    logic        wrap_sel_old;
    logic        wrap_sel_new;

    assign tick = fi.run && (div_reg == 32'(UFRAME_CYCLES - 1));
    assign index_next = index_reg + 14'h0001;

    function automatic logic wrap_bit(input logic [1:0] size, input logic [13:0] idx);
        if (size == `FLS_1024) begin
            wrap_bit = idx[`WRAP_BIT_1024];
        end else if (size == `FLS_512) begin
            wrap_bit = idx[`WRAP_BIT_512];
        end else begin
            wrap_bit = idx[`WRAP_BIT_256];
        end
    endfunction

    assign wrap_sel_old = wrap_bit(fi.list_size, index_reg);
    assign wrap_sel_new = wrap_bit(fi.list_size, index_next);

    always_ff @(posedge core_clk) begin
        if (reset || !fi.run || tick) begin
            div_reg <= 32'h00000000;
        end else begin
            div_reg <= div_reg + 32'h00000001;
        end
    end

    // ==========================================================
    // frame index and rollover
    always_ff @(posedge core_clk) begin
        if (reset) begin
            index_reg <= 14'h0000;
            wrap_reg  <= 1'b0;
        end else begin
            wrap_reg <= tick && (wrap_sel_old != wrap_sel_new);
            if (tick) begin
                index_reg <= index_next;
            end
        end
    end

    // ==========================================================
    // current list index from size
    always_ff @(posedge core_clk) begin
        if (reset) begin
            list_index_reg <= 10'h000;
        end else if (fi.list_size == `FLS_1024) begin
            list_index_reg <= index_reg[12:3];
        end else if (fi.list_size == `FLS_512) begin
            list_index_reg <= {1'b0, index_reg[11:3]};
        end else begin
            list_index_reg <= {2'b00, index_reg[10:3]};
        end
    end

    assign fi.frame_index = index_reg;
    assign fi.list_index  = list_index_reg;
    assign fi.wrap        = wrap_reg;

endmodule // frame_index_counter

//--- pipeline_model.sv
`timescale 1ns/1ps
// ==========================================================
// bus transaction pipeline
module pipeline_model (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic slow,
    input  wire logic schedule_fetch_en,
    input  wire logic transaction_abort,
    output logic      pipeline_idle,
    output logic      transfer_done_event
);
    logic [2:0] left_reg;
    assign pipeline_idle = (left_reg == 3'h0);
    always_ff @(posedge core_clk) begin
        transfer_done_event <= 1'b0;
        if (reset || transaction_abort) begin
            left_reg <= 3'h0;
        end else if (left_reg != 3'h0) begin
            left_reg            <= left_reg - 3'h1;
            transfer_done_event <= (left_reg == 3'h1);
        end else if (schedule_fetch_en) begin
            left_reg <= slow ? 3'h6 : 3'h1;
        end
    end
endmodule // pipeline_model

//--- tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// testbench
module tb_top;
    localparam int          RST_CYC = 16;
    localparam logic [31:0] STS_M   = 32'hFFFFFFF6;
    typedef struct packed {logic [31:0] val; logic [31:0] mask;} note_t;
    logic        core_clk  = 1'b0;
    logic        reset     = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        cap       = 1'b1;
    logic        slow      = 1'b0;
    logic [5:0]  ev        = 6'h00;
    logic [2:0]  lv        = 3'h0;
    logic [7:0]  lf        = 8'h46;
    logic [5:0]  flags     = 6'h00;
    logic [1:0]  frame_list_size       = 2'h0;
    logic        rd_seen   = 1'b0;
    logic        idle, done, run_stop, halted_flag, fetch_en, busy, abort, revert;
    logic [31:0] reg_rdata;
    logic [13:0] frame_index;
    logic [13:0] fi;
    logic [9:0]  frame_list_index;
    note_t       notes[$];
    note_t       cur;
    int          mismatches = 0;
    int          compares   = 0;

    always #5 core_clk = ~core_clk;

    ehci_command_status_regs #(.UFRAME_CYCLES(4), .CTRL_RESET_CYCLES(RST_CYC))
        ehci_command_status_regs_i (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .programmable_list_cap(cap), .pipeline_idle(idle), .transfer_done_event(done),
        .transfer_error_event(ev[1]), .port_change_event(ev[2]), .host_error_event(ev[4]),
        .async_advance_event(ev[5]), .async_schedule_state(lv[2]),
        .periodic_sched_state(lv[1]), .empty_async_detect(lv[0]), .run_stop(run_stop),
        .halted_flag(halted_flag), .schedule_fetch_en(fetch_en),
        .controller_reset_active(busy), .transaction_abort(abort), .port_owner_revert(revert),
        .frame_index(frame_index), .frame_list_index(frame_list_index));
    pipeline_model pipeline_model_i (.core_clk(core_clk), .reset(reset), .slow(slow),
        .schedule_fetch_en(fetch_en), .transaction_abort(abort), .pipeline_idle(idle),
        .transfer_done_event(done));

    // ==========================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] sts(input logic h);
        return {16'h0000, lv, h, 6'h00, flags};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        notes.push_back('{v & m, m});
        @(posedge core_clk);
        reg_read <= 1'b0;
    endtask
    task automatic pulse(input int b);
        @(posedge core_clk);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev       <= 6'h00;
        flags[b] = 1'b1;
    endtask
    task automatic wait_halt();
        for (int i = 0; i < 60 && halted_flag !== 1'b1; i++) @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // read monitor
    always @(posedge core_clk) begin
        rd_seen <= reg_read;
        if (rd_seen && notes.size() > 0) begin
            cur = notes.pop_front();
            check(reg_rdata & cur.mask, cur.val, "register read");
        end
    end

    initial begin
        #300000;
        mismatches++;
        summarize();
    end

    // ==========================================================
    // scenarios
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(8'h24, sts(1'b1), STS_M);
        rd(8'h20, 32'h00000000, 32'hFFFFFFFF);
        for (int c = 0; c < 4; c++) begin
            wr(8'h20, {28'h0000000, c[1:0], 2'h0});
            if (c < 3) frame_list_size = c[1:0];
            rd(8'h20, {28'h0000000, frame_list_size, 2'h0}, 32'hFFFFFFFF);
        end
        @(posedge core_clk) cap <= 1'b0;
        wr(8'h20, 32'h00000004);
        rd(8'h20, {28'h0000000, frame_list_size, 2'h0}, 32'hFFFFFFFF);
        @(posedge core_clk) cap <= 1'b1;
        $display("size field test done");
        for (int s = 0; s < 3; s++) begin
            @(posedge core_clk) slow <= s[0];
            frame_list_size = s[1:0];
            wait_halt();
            wr(8'h20, {28'h0000000, frame_list_size, 2'h1});
            repeat (40) @(posedge core_clk);
            fi = frame_index;
            @(posedge core_clk);
            check({22'h0, frame_list_index}, {22'h0, s == 0 ? fi[12:3] : s == 1 ?
                {1'b0, fi[11:3]} : {2'h0, fi[10:3]}}, "list index");
            rd(8'h24, sts(1'b0), STS_M);
            wr(8'h20, {28'h0000000, frame_list_size, 2'h0});
            wait_halt();
            rd(8'h24, sts(1'b1), STS_M);
            rd(8'h24, 32'h00000001, 32'h00000001);
            wr(8'h24, 32'h00000001);
            rd(8'h24, 32'h00000000, 32'h00000001);
        end
        $display("run and index test done");
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            @(posedge core_clk) lv <= lf[7:5];
            pulse(k == 3 ? 5 : k == 2 ? 4 : k + 1);
            rd(8'h24, sts(1'b1), STS_M);
            lf = lfsr(lf);
            wr(8'h24, {26'h0000000, lf[5:0]});
            flags = flags & ~(lf[5:0] & 6'h1F);
            rd(8'h24, sts(1'b1), STS_M);
        end
        $display("status flag test done");
        wr(8'h20, {28'h0000000, frame_list_size, 2'h1});
        pulse(4);
        wait_halt();
        rd(8'h20, {28'h0000000, frame_list_size, 2'h0}, 32'hFFFFFFFF);
        rd(8'h24, sts(1'b1), STS_M);
        wr(8'h28, 32'hFFFFFFFF);
        rd(8'h28, 32'h00000000, 32'hFFFFFFFF);
        $display("host error test done");
        wait_halt();
        wr(8'h20, 32'h00000002);
        rd(8'h20, 32'h00000002, 32'hFFFFFFFF);
        wr(8'h20, 32'h00000000);
        rd(8'h20, 32'h00000002, 32'hFFFFFFFF);
        repeat (RST_CYC + 4) @(posedge core_clk);
        flags = 6'h00;
        frame_list_size   = 2'h0;
        rd(8'h20, 32'h00000000, 32'hFFFFFFFF);
        rd(8'h24, sts(1'b1), STS_M);
        $display("controller reset test done");
        wr(8'h20, 32'h00000005);
        fi = frame_index;
        for (int i = 0; i < 20000 && frame_index[12] === fi[12]; i++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        rd(8'h24, 32'h00000008, 32'h00000008);
        wr(8'h24, 32'h00000008);
        rd(8'h24, 32'h00000000, 32'h00000008);
        wr(8'h20, 32'h00000008);
        wait_halt();
        repeat (3) @(posedge core_clk);
        $display("rollover test done");
        summarize();
    end
endmodule // tb_top
